/* File: src/bsp_ctrl.sv */
// sequencing, code stepping and protection for a single-phase buck controller.
// assumes comparator results arrive as synchronous logic levels; pwm_req from modulator.
`timescale 1ns/1ps
`default_nettype none
module bsp_ctrl
   import bsp_pkg::*;
#(
   parameter int STEP_TICK = STEP_TICK_CYC,
   parameter int MASK_CNT = MASK_CYC,
   parameter int SOFT_CNT = SOFT_TR_CYC,
   parameter int LATCH_CNT = LATCH_WAIT_CYC,
   parameter bit ALT_VARIANT = 1'b0
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic graphics_mode_strap,
   input wire logic [CODE_W-1:0] voltage_id_code,
   input wire logic enable,
   input wire logic supply_ok_level,
   input wire logic supply_low_level,
   input wire logic overvoltage_trip,
   input wire logic rev_below_300mv,
   input wire logic rev_above_100mv,
   input wire logic current_over_limit,
   input wire logic out_below_200mv,
   input wire logic out_in_window,
   input wire logic sw_zero_cross,
   input wire logic pwm_req,
   output logic high_side_gate,
   output logic low_side_gate,
   output logic output_ok_flag,
   output logic ripple_mode,
   output logic current_limit_reg,
   output logic secondary_clamp,
   output logic [CODE_W-1:0] ref_code,
   output logic [15:0] ref_mv10,
   output logic latched_off
);
   // sequencing state and reference stepping
   bsp_state_t st_r;
   bsp_state_t st_nxt;
   logic [CODE_W-1:0] ref_r;
   logic [CODE_W-1:0] ref_nxt;
   logic [CODE_W-1:0] tgt_r;
   logic [CODE_W-1:0] tgt_nxt;
   logic [CODE_W-1:0] seen_r;
   logic [CODE_W-1:0] seen_nxt;
   // down-counters: skew filter, ok mask, soft transient, step tick, latch-off wait
   logic [31:0] skew_r;
   logic [31:0] skew_nxt;
   logic [31:0] mask_r;
   logic [31:0] mask_nxt;
   logic [31:0] soft_r;
   logic [31:0] soft_nxt;
   logic [31:0] tick_r;
   logic [31:0] tick_nxt;
   logic [31:0] lat_r;
   logic [31:0] lat_nxt;
   // reverse-voltage and light-load flags
   logic rv_r;
   logic rv_nxt;
   logic dcm_off_r;
   logic dcm_off_nxt;
   // registered gate drives, output-ok and reference level
   logic hs_r;
   logic hs_nxt;
   logic ls_r;
   logic ls_nxt;
   logic ok_r;
   logic ok_nxt;
   logic [15:0] mv_r;
   logic [15:0] mv_nxt;
   // decoded helpers
   logic [CODE_W-1:0] boot;
   logic run_ok;
   logic tick;
   logic masked;

   // boot code per variant
   assign boot = ALT_VARIANT ? BOOT_CODE_ALT : BOOT_CODE_BASE;
   // switching allowed only with supply good and enable high
   assign run_ok = supply_ok_level && !supply_low_level && enable;

   // step tick and ok-mask status
   assign tick = (tick_r == 32'h0);
   assign masked = (mask_r != 32'h0);

   // step tick for the reference walk
   always_comb begin
      tick_nxt = tick ? 32'(STEP_TICK - 1) : tick_r - 32'h1;
   end

   // reverse-voltage hysteresis, kept through every latch state; set wins
   always_comb begin
      rv_nxt = rv_r;
      if (rev_below_300mv) begin
         rv_nxt = 1'b1;
      end else if (rev_above_100mv) begin
         rv_nxt = 1'b0;
      end
   end

   // zero crossing ends the low-side pulse until the next high-side pulse
   always_comb begin
      dcm_off_nxt = dcm_off_r;
      if (pwm_req) begin
         dcm_off_nxt = 1'b0;
      end else if (sw_zero_cross) begin
         dcm_off_nxt = 1'b1;
      end
   end

   // reference level follows the next code, so it lines up with ref_code
   always_comb begin
      mv_nxt = CODE0_MV10 - 16'(STEP_MV10 * {9'h0, ref_nxt});
   end

   // next-state logic
   always_comb begin
      st_nxt = st_r;
      ref_nxt = ref_r;
      tgt_nxt = tgt_r;
      seen_nxt = seen_r;
      skew_nxt = (skew_r != 32'h0) ? skew_r - 32'h1 : 32'h0;
      mask_nxt = masked ? mask_r - 32'h1 : 32'h0;
      soft_nxt = (soft_r != 32'h0) ? soft_r - 32'h1 : 32'h0;
      lat_nxt = lat_r;
      // code change detection and skew filter in graphics mode
      if (graphics_mode_strap && voltage_id_code != seen_r) begin
         seen_nxt = voltage_id_code;
         skew_nxt = 32'(SKEW_CYC);
      end else if (graphics_mode_strap && skew_r == 32'h1 && st_r != BSP_OFF) begin
         if (tgt_r != seen_r) begin
            tgt_nxt = seen_r;
            mask_nxt = 32'(MASK_CNT);
            soft_nxt = 32'(SOFT_CNT);
         end
      end
      // reference walks one code per tick toward target
      if (st_r != BSP_OFF && tick && ref_r != tgt_r) begin
         ref_nxt = (ref_r > tgt_r) ? ref_r - 7'h1 : ref_r + 7'h1;
      end
      case (st_r)
         BSP_OFF: begin
            ref_nxt = CODE_ZERO_V;
            lat_nxt = 32'h0;
            if (run_ok) begin
               tgt_nxt = graphics_mode_strap ? voltage_id_code : boot;
               seen_nxt = voltage_id_code;
               mask_nxt = 32'(MASK_CNT);
               st_nxt = BSP_RAMP;
            end
         end
         BSP_RAMP: begin
            mask_nxt = 32'(MASK_CNT);
            if (ref_r == tgt_r && tick) begin
               st_nxt = BSP_RUN;
            end
         end
         BSP_RUN: begin
            if (current_over_limit && !ok_r && !masked) begin
               lat_nxt = 32'(LATCH_CNT);
               st_nxt = BSP_LIMIT_WAIT;
            end
         end
         BSP_LIMIT_WAIT: begin
            lat_nxt = lat_r - 32'h1;
            if (out_in_window) begin
               st_nxt = BSP_RUN;
            end else if (lat_r == 32'h1) begin
               st_nxt = BSP_LATCH;
            end
         end
         BSP_LATCH, BSP_OV_LATCH: begin
            st_nxt = st_r;
         end
         default: st_nxt = BSP_OFF;
      endcase
      if (overvoltage_trip && st_r != BSP_OFF) begin
         st_nxt = BSP_OV_LATCH;
      end
      // enable low or supply low shuts down and clears any latch
      if (!run_ok) begin
         st_nxt = BSP_OFF;
      end
   end

   // gate and flag decode
   always_comb begin
      hs_nxt = 1'b0;
      ls_nxt = 1'b0;
      ok_nxt = 1'b0;
      case (st_nxt)
         BSP_OV_LATCH: begin
            ls_nxt = !rv_nxt;
         end
         BSP_RAMP, BSP_RUN, BSP_LIMIT_WAIT: begin
            if (!rv_nxt) begin
               hs_nxt = pwm_req;
               ls_nxt = !pwm_req && !dcm_off_nxt;
            end
            ok_nxt = (st_nxt != BSP_RAMP) && (mask_nxt != 32'h0 || out_in_window);
         end
         default: begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
         end
      endcase
      if (overvoltage_trip && st_nxt != BSP_OFF) begin
         hs_nxt = 1'b0;
      end
   end

   // state and reference registers
   always_ff @(posedge clock) begin
      if (srst) begin
         st_r <= BSP_OFF;
         ref_r <= CODE_ZERO_V;
         tgt_r <= CODE_ZERO_V;
         seen_r <= 7'h0;
      end else begin
         st_r <= st_nxt;
         ref_r <= ref_nxt;
         tgt_r <= tgt_nxt;
         seen_r <= seen_nxt;
      end
   end

   // timer registers
   always_ff @(posedge clock) begin
      if (srst) begin
         skew_r <= 32'h0;
         mask_r <= 32'h0;
         soft_r <= 32'h0;
         lat_r <= 32'h0;
      end else begin
         skew_r <= skew_nxt;
         mask_r <= mask_nxt;
         soft_r <= soft_nxt;
         lat_r <= lat_nxt;
      end
   end

   // step tick register
   always_ff @(posedge clock) begin
      if (srst) begin
         tick_r <= 32'h0;
      end else begin
         tick_r <= tick_nxt;
      end
   end

   // reverse and light-load flag registers
   always_ff @(posedge clock) begin
      if (srst) begin
         rv_r <= 1'b0;
         dcm_off_r <= 1'b0;
      end else begin
         rv_r <= rv_nxt;
         dcm_off_r <= dcm_off_nxt;
      end
   end

   // gate drive and output-ok registers
   always_ff @(posedge clock) begin
      if (srst) begin
         hs_r <= 1'b0;
         ls_r <= 1'b0;
         ok_r <= 1'b0;
      end else begin
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
         ok_r <= ok_nxt;
      end
   end

   // reference level register
   always_ff @(posedge clock) begin
      if (srst) begin
         mv_r <= CODE0_MV10 - 16'(STEP_MV10 * {9'h0, CODE_ZERO_V});
      end else begin
         mv_r <= mv_nxt;
      end
   end

   // gate drives and output-ok
   assign high_side_gate = hs_r;
   assign low_side_gate = ls_r;
   assign output_ok_flag = ok_r;

   // stepping reference and its voltage
   assign ref_code = ref_r;
   assign ref_mv10 = mv_r;

   // limit regulation whenever switching, start-up clamp, mode and latch status
   assign current_limit_reg = current_over_limit
      && (st_r == BSP_RAMP || st_r == BSP_RUN || st_r == BSP_LIMIT_WAIT);
   assign secondary_clamp = (st_r == BSP_RAMP) && out_below_200mv;
   assign ripple_mode = !((st_r == BSP_RAMP) || current_over_limit || soft_r != 32'h0);
   assign latched_off = (st_r == BSP_LATCH) || (st_r == BSP_OV_LATCH);
endmodule : bsp_ctrl
`default_nettype wire

/* File: common/bsp_pkg.sv */
// constants, state types and timing counts for buck sequencing and protection.
// assumes a 250 MHz clock; analog comparators are resolved outside as logic levels.
// How it works
// - strap low: power-up steps code by code up to the boot code
// - strap high: power-up steps code by code to the applied voltage code
// - boot code gives 1.1 V on the base variant, 1.2 V on the alternative
// - graphics mode: a changed code is ignored for at least 400 ns
// - every accepted code change restarts the output-ok mask timer
// - the reference walks through every intermediate code to the final one
// - above the limit current, regulation holds average current at the limit
// - ripple mode by default, fixed-clock modulation while overloaded
// - output-ok lost during current limiting, wait 8 ms, then latch off
// - latch-off clears only by supply cycle or an enable low pulse
// - output below 200 mV at start-up clamps error level at 1.5 V minimum
// - continuous conduction drives the two gates complementary
// - discontinuous conduction turns low side off at the zero crossing
// - overvoltage forces low side high and high side low
// - overvoltage trip latches off until supply cycle or enable pulse
// - reverse voltage drops both gates; ends once above -100 mV
// - reverse monitoring stays active during overvoltage latch-off
// - switching starts only with supply ok and enable high
// - supply low or enable low shuts down, gates low, output-ok low
// - output-ok masked about 130 us after code change and soft-start
// - output-ok high only within -300 mV / +200 mV of the code voltage
// - fixed-clock during soft-start, overload and 110 us after code change
// - code zero is 1.5000 V, each increment lowers by 12.5 mV
package bsp_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SKEW_IGNORE_NS = 400;
   localparam int SKEW_CYC = (SKEW_IGNORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MASK_US = 130;
   localparam int MASK_CYC = (MASK_US * 1000000) / CLK_PERIOD_PS;
   localparam int SOFT_TR_US = 110;
   localparam int SOFT_TR_CYC = (SOFT_TR_US * 1000000) / CLK_PERIOD_PS;
   localparam int LATCH_WAIT_MS = 8;
   localparam int LATCH_WAIT_CYC = (LATCH_WAIT_MS * 1000000) / 4 * 1000 / 1000;
   localparam int STEP_TICK_CYC = 250;
   localparam int CODE_W = 7;
   localparam logic [6:0] CODE_ZERO_V = 7'h7f;   // highest code, lowest voltage
   localparam logic [6:0] BOOT_CODE_BASE = 7'h20; // 1.1000 V
   localparam logic [6:0] BOOT_CODE_ALT = 7'h18;  // 1.2000 V
   localparam logic [15:0] CODE0_MV10 = 16'h3a98; // 1.5000 V in 0.1 mV
   localparam logic [15:0] STEP_MV10 = 16'h007d;  // 12.5 mV in 0.1 mV
   typedef enum logic [2:0] {
      BSP_OFF = 3'b000,
      BSP_RAMP = 3'b001,
      BSP_RUN = 3'b010,
      BSP_LIMIT_WAIT = 3'b011,
      BSP_LATCH = 3'b100,
      BSP_OV_LATCH = 3'b101
   } bsp_state_t;
endpackage : bsp_pkg

/* File: tb/bsp_code_src.sv */
// chipset-side model driving the applied voltage code.
// assumes the bench sets target; bits settle lowest first.
`timescale 1ns/1ps
`default_nettype none
module bsp_code_src (
   input wire logic clock,
   input wire logic [6:0] target,
   output logic [6:0] voltage_id_code
);
   logic [6:0] diff;
   initial voltage_id_code = 7'h7f;
   // inter-bit skew: one differing bit flips per clock
   always @(posedge clock) begin
      diff = voltage_id_code ^ target;
      voltage_id_code <= #1 voltage_id_code ^ (diff & (~diff + 7'h01));
   end
endmodule // bsp_code_src
`default_nettype wire

/* File: tb/bsp_ctrl_assertions.sv */
// port-level checks for the sequencing and protection block.
// assumes one clock domain and sync reset srst.
`timescale 1ns/1ps
`default_nettype none
module bsp_ctrl_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic enable,
   input wire logic supply_ok_level,
   input wire logic supply_low_level,
   input wire logic overvoltage_trip,
   input wire logic rev_below_300mv,
   input wire logic rev_above_100mv,
   input wire logic current_over_limit,
   input wire logic sw_zero_cross,
   input wire logic high_side_gate,
   input wire logic low_side_gate,
   input wire logic output_ok_flag,
   input wire logic ripple_mode,
   input wire logic current_limit_reg,
   input wire logic [6:0] ref_code,
   input wire logic latched_off
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic run_ok;
   // supply and enable both good
   assign run_ok = enable && supply_ok_level && !supply_low_level;
   sequence run_steady; run_ok [*3]; endsequence
   sequence ov_hit;
      run_steady ##0 (overvoltage_trip && rev_above_100mv && !rev_below_300mv);
   endsequence
   step_by_one_a: assert property ($past(run_ok) && $past(run_ok, 2) && $changed(ref_code)
      |-> ref_code == $past(ref_code) + 7'h01 || ref_code == $past(ref_code) - 7'h01)
      else $error("reference jumped");
   shut_down_a: assert property (!run_ok [*3]
      |-> !high_side_gate && !low_side_gate && !output_ok_flag) else $error("not shut");
   ov_latch_a: assert property (ov_hit |-> ##[1:2] latched_off)
      else $error("no latch");
   crowbar_on_a: assert property (ov_hit ##1 (run_ok && rev_above_100mv && !rev_below_300mv) [*2]
      |-> low_side_gate && !high_side_gate) else $error("no crowbar");
   reverse_off_a: assert property (rev_below_300mv
      |-> ##[1:2] (!low_side_gate && !high_side_gate)) else $error("reverse gates on");
   zero_cross_a: assert property (sw_zero_cross && !overvoltage_trip && !latched_off
      |-> ##[1:2] !low_side_gate) else $error("low side on");
   no_overlap_a: assert property (!(high_side_gate && low_side_gate))
      else $error("both gates on");
   overload_mode_a: assert property (run_steady ##0 current_over_limit [*2]
      |-> latched_off || (!ripple_mode && current_limit_reg)) else $error("no limit mode");
endmodule // bsp_ctrl_checker
bind bsp_ctrl bsp_ctrl_checker chk (.clock, .srst, .enable, .supply_ok_level,
   .supply_low_level, .overvoltage_trip, .rev_below_300mv, .rev_above_100mv, .current_over_limit,
   .sw_zero_cross, .high_side_gate, .low_side_gate, .output_ok_flag, .ripple_mode,
   .current_limit_reg, .ref_code, .latched_off);
`default_nettype wire

/* File: tb/tb.sv */
// bench for bsp_ctrl: ramps, code change, limit and protection latches.
// assumes shortened counts so the run stays short.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bsp_pkg::*;
   logic clock = 1'b0, srst = 1'b1, graphics_mode_strap = 1'b0, enable = 1'b0;
   logic supply_ok_level = 1'b1, supply_low_level = 1'b0, overvoltage_trip = 1'b0;
   logic rev_below_300mv = 1'b0, rev_above_100mv = 1'b1, current_over_limit = 1'b0;
   logic out_below_200mv = 1'b0, out_in_window = 1'b1, sw_zero_cross = 1'b0, pwm_req = 1'b0;
   logic [6:0] target = 7'h28, voltage_id_code, ref_code, ref_code_alt;
   logic [15:0] ref_mv10;
   logic high_side_gate, low_side_gate, output_ok_flag, ripple_mode, current_limit_reg;
   logic secondary_clamp, latched_off;
   int mismatches = 0, comparisons = 0, n;
   always #2 clock = ~clock;
   bsp_code_src src (.clock, .target, .voltage_id_code);
   bsp_ctrl #(.STEP_TICK(4), .MASK_CNT(20), .SOFT_CNT(20), .LATCH_CNT(50)) uut (.clock, .srst,
      .graphics_mode_strap, .voltage_id_code, .enable, .supply_ok_level, .supply_low_level,
      .overvoltage_trip, .rev_below_300mv, .rev_above_100mv, .current_over_limit,
      .out_below_200mv, .out_in_window, .sw_zero_cross, .pwm_req, .high_side_gate,
      .low_side_gate, .output_ok_flag, .ripple_mode, .current_limit_reg, .secondary_clamp,
      .ref_code, .ref_mv10, .latched_off);
   bsp_ctrl #(.STEP_TICK(4), .MASK_CNT(20), .SOFT_CNT(20), .LATCH_CNT(50), .ALT_VARIANT(1'b1))
      uut_alt (.clock, .srst, .graphics_mode_strap, .voltage_id_code, .enable, .supply_ok_level,
      .supply_low_level, .overvoltage_trip, .rev_below_300mv, .rev_above_100mv,
      .current_over_limit, .out_below_200mv, .out_in_window, .sw_zero_cross, .pwm_req,
      .high_side_gate(), .low_side_gate(), .output_ok_flag(), .ripple_mode(),
      .current_limit_reg(), .secondary_clamp(), .ref_code(ref_code_alt), .ref_mv10(),
      .latched_off());
   task tick(int k); repeat (k) @(posedge clock); #1; endtask
   task fail(string m); mismatches++; $display("CHECK FAILED at %0t: %s", $time, m); endtask
   task chk_bit(logic g, logic e, string m); comparisons++; if (g !== e) fail(m); endtask
   task chk_val(logic [15:0] g, logic [15:0] e, string m);
      comparisons++;
      if (g !== e) fail(m);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // bounded wait: sel 1 for latch-off, else for reference code c
   task wait_on(bit sel, logic [6:0] c);
      n = 0;
      while ((sel ? latched_off !== 1'b1 : ref_code !== c) && n < 1000) begin tick(1); n++; end
      if (n == 1000) begin fail("wait timed out"); print_verdict; end
   endtask
   initial begin
      tick(4); srst = 1'b0;
      chk_val(ref_code, 16'h7f, "reset code");
      chk_bit(high_side_gate | low_side_gate | output_ok_flag, 1'b0, "reset outs");
      enable = 1'b1; out_below_200mv = 1'b1; tick(2);
      chk_bit(secondary_clamp, 1'b1, "clamp");
      chk_bit(ripple_mode, 1'b0, "soft-start mode");
      out_below_200mv = 1'b0; wait_on(0, BOOT_CODE_BASE);
      chk_val(ref_mv10, 16'h2af8, "boot level");
      target = 7'h10; tick(300);
      chk_val(ref_code, BOOT_CODE_BASE, "boot held");
      chk_val(ref_code_alt, BOOT_CODE_ALT, "alt boot held");
      $display("test boot done");
      enable = 1'b0; graphics_mode_strap = 1'b1; target = 7'h28; tick(2);
      enable = 1'b1; wait_on(0, 7'h28); tick(30);
      chk_bit(output_ok_flag, 1'b1, "ok in window");
      target = 7'h2c; tick(60);
      chk_val(ref_code, 7'h28, "skew ignored");
      wait_on(0, 7'h29); out_in_window = 1'b0; tick(4);
      chk_bit(output_ok_flag, 1'b1, "ok masked");
      chk_bit(ripple_mode, 1'b0, "soft transient");
      wait_on(0, 7'h2c); tick(40);
      chk_bit(output_ok_flag, 1'b0, "ok out of window");
      chk_bit(ripple_mode, 1'b1, "ripple default");
      chk_val(ref_mv10, 16'h251c, "code level");
      $display("test code change done");
      out_in_window = 1'b1; current_over_limit = 1'b1; tick(3);
      chk_bit(current_limit_reg, 1'b1, "limit");
      out_in_window = 1'b0; wait_on(1, 7'h00);
      chk_bit(n >= 50 && n <= 60, 1'b1, "latch delay");
      current_over_limit = 1'b0; out_in_window = 1'b1; tick(5);
      chk_bit(latched_off, 1'b1, "latch held");
      enable = 1'b0; tick(1); enable = 1'b1; tick(2);
      chk_bit(latched_off, 1'b0, "latch cleared");
      overvoltage_trip = 1'b1; tick(1); overvoltage_trip = 1'b0; tick(2);
      chk_bit(latched_off & low_side_gate & !high_side_gate, 1'b1, "crowbar");
      rev_below_300mv = 1'b1; rev_above_100mv = 1'b0; tick(2);
      chk_bit(low_side_gate, 1'b0, "reverse off");
      rev_below_300mv = 1'b0; tick(3);
      chk_bit(low_side_gate, 1'b0, "reverse held");
      rev_above_100mv = 1'b1; tick(2);
      chk_bit(low_side_gate, 1'b1, "crowbar back");
      $display("test latches done");
      enable = 1'b0; tick(1); enable = 1'b1; wait_on(0, 7'h2c);
      pwm_req = 1'b1; tick(2);
      chk_bit(high_side_gate & !low_side_gate, 1'b1, "high phase");
      pwm_req = 1'b0; tick(2);
      chk_bit(!high_side_gate & low_side_gate, 1'b1, "low phase");
      sw_zero_cross = 1'b1; tick(2);
      chk_bit(low_side_gate, 1'b0, "zero cross");
      sw_zero_cross = 1'b0;
      pwm_req = 1'b1;
      rev_below_300mv = 1'b1;
      rev_above_100mv = 1'b0;
      tick(2);
      chk_bit(high_side_gate | low_side_gate, 1'b0, "reverse in run");
      rev_below_300mv = 1'b0;
      rev_above_100mv = 1'b1;
      pwm_req = 1'b0;
      tick(2);
      supply_low_level = 1'b1;
      tick(3);
      chk_bit(high_side_gate | low_side_gate | output_ok_flag, 1'b0, "undervoltage");
      $display("test switching done");
      print_verdict;
   end
endmodule // tb
`default_nettype wire
